// ===== logic/pgsn_regs.vh
// Register map, reset values and field constants of the port group block
`ifndef PGSN_REGS_VH
`define PGSN_REGS_VH

`define PGSN_ADDR_IRQ_DIR     16'hffcd
`define PGSN_ADDR_ANA_LVL     16'hffce
`define PGSN_ADDR_IRQ_DATA    16'hffcf
`define PGSN_ADDR_SER_DIR     16'hffd0
`define PGSN_ADDR_SER_DATA    16'hffd2

`define PGSN_RST_IRQ_DIR      8'hf0
`define PGSN_RST_IRQ_DATA     8'he0
`define PGSN_RST_SER_DIR      8'hc0
`define PGSN_RST_SER_DATA     8'hc0

`define PGSN_FIXED_IRQ_DATA   8'he0
`define PGSN_FIXED_SER_DATA   8'hc0
`define PGSN_DIR_READ         8'hff
`define PGSN_UNMAPPED_READ    8'h00
`define PGSN_ZERO8            8'h00
`define PGSN_ANA_PAD          4'h0

`define PGSN_SYNC_W           10
`define PGSN_SYNC_ANA_LSB     0
`define PGSN_SYNC_IRQ_LSB     4
`define PGSN_SYNC_SER_LSB     6
`define PGSN_SYNC_HWS_BIT     9

`define PGSN_SER_TX_PIN       0
`define PGSN_SER_RX_PIN       1
`define PGSN_SER_CK_PIN       2

`endif

// ===== logic/pgsn_top.v
// Port group block: analog input group, interrupt group and serial group pins
`timescale 1ns/100ps
`include "pgsn_regs.vh"

module pgsn_top
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // Hardware standby pin, active high
  input  wire        hw_standby_i,
  // Register port
  input  wire [15:0] addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  // Analog group pins
  input  wire [3:0]  ana_pin_i,
  output reg  [3:0]  adc_in_o,
  // Interrupt group pins
  input  wire [1:0]  irq_pin_i,
  output reg  [1:0]  irq_pin_o,
  output reg  [1:0]  irq_pin_oe_o,
  output reg         ext_interrupt_zero_o,
  output reg         ext_interrupt_one_o,
  // Serial group pins (index 0,1,2 = pins 0,2,4)
  input  wire [2:0]  ser_pin_i,
  output reg  [2:0]  ser_pin_o,
  output reg  [2:0]  ser_pin_oe_o,
  output reg         ext_interrupt_four_o,
  // Serial interface side
  input  wire        serial_receiver_enable_i,
  input  wire        serial_transmitter_enable_i,
  input  wire        txd_i,
  input  wire        sck_own_i,
  input  wire        sck_drive_i,
  input  wire        sck_out_i,
  output reg         rxd_o,
  output reg         sck_in_o
);

  reg  [`PGSN_SYNC_W-1:0] sync1_r;
  reg  [`PGSN_SYNC_W-1:0] sync2_r;
  reg  [`PGSN_SYNC_W-1:0] sync3_r;
  reg  [`PGSN_SYNC_W-1:0] filt_r;
  wire [`PGSN_SYNC_W-1:0] filt_nxt;
  wire [`PGSN_SYNC_W-1:0] raw_in;

  reg  [7:0] irq_dir_r;
  reg  [7:0] irq_dir_nxt;
  reg  [7:0] irq_data_r;
  reg  [7:0] irq_data_nxt;
  reg  [7:0] ser_dir_r;
  reg  [7:0] ser_dir_nxt;
  reg  [7:0] ser_data_r;
  reg  [7:0] ser_data_nxt;
  reg  [7:0] rdata_nxt;

  reg  [1:0] irq_out_nxt;
  reg  [1:0] irq_oe_nxt;
  reg  [2:0] ser_out_nxt;
  reg  [2:0] ser_oe_nxt;

  wire [3:0] ana_lvl;
  wire [1:0] irq_lvl;
  wire [2:0] ser_lvl;
  wire       hw_stby;
  wire [7:0] ser_lvl_wide;
  wire [7:0] ser_dir_used;

  // Mixed-width read of pin vs. stored bit, shared by both two-way groups
  function [7:0] pgsn_port_read;
    input [7:0] dir;
    input [7:0] data;
    input [7:0] lvl;
    input [7:0] fixed;
    begin
      pgsn_port_read = fixed | (dir & data) | (~dir & lvl & ~fixed);
    end
  endfunction

  assign raw_in = {hw_standby_i, ser_pin_i, irq_pin_i, ana_pin_i};

  // A change counts only once stages two and three agree
  assign filt_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_r <= {`PGSN_SYNC_W{1'b0}};
      sync2_r <= {`PGSN_SYNC_W{1'b0}};
      sync3_r <= {`PGSN_SYNC_W{1'b0}};
      filt_r  <= {`PGSN_SYNC_W{1'b0}};
    end
    else
    begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= filt_nxt;
    end
  end

  assign ana_lvl = filt_r[`PGSN_SYNC_ANA_LSB +: 4];
  assign irq_lvl = filt_r[`PGSN_SYNC_IRQ_LSB +: 2];
  assign ser_lvl = filt_r[`PGSN_SYNC_SER_LSB +: 3];
  assign hw_stby = filt_r[`PGSN_SYNC_HWS_BIT];

  // Serial pins sit at register bits 0, 2 and 4
  assign ser_lvl_wide = {3'b000, ser_lvl[2], 1'b0, ser_lvl[1], 1'b0, ser_lvl[0]};
  assign ser_dir_used = {3'b000, ser_dir_r[4], 1'b0, ser_dir_r[2], 1'b0, ser_dir_r[0]};

  // Register writes; hardware standby reloads reset values and blocks writes
  always @*
  begin
    irq_dir_nxt  = irq_dir_r;
    irq_data_nxt = irq_data_r;
    ser_dir_nxt  = ser_dir_r;
    ser_data_nxt = ser_data_r;
    if (hw_stby)
    begin
      irq_dir_nxt  = `PGSN_RST_IRQ_DIR;
      irq_data_nxt = `PGSN_RST_IRQ_DATA;
      ser_dir_nxt  = `PGSN_RST_SER_DIR;
      ser_data_nxt = `PGSN_RST_SER_DATA;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `PGSN_ADDR_IRQ_DIR:
          irq_dir_nxt = wdata_i;
        `PGSN_ADDR_IRQ_DATA:
          irq_data_nxt = wdata_i | `PGSN_FIXED_IRQ_DATA;
        `PGSN_ADDR_SER_DIR:
          ser_dir_nxt = wdata_i;
        `PGSN_ADDR_SER_DATA:
          ser_data_nxt = wdata_i | `PGSN_FIXED_SER_DATA;
        default:
          irq_dir_nxt = irq_dir_r;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always @*
  begin
    rdata_nxt = `PGSN_ZERO8;
    if (rd_i)
    begin
      case (addr_i)
        `PGSN_ADDR_IRQ_DIR:
          rdata_nxt = `PGSN_DIR_READ;
        `PGSN_ADDR_SER_DIR:
          rdata_nxt = `PGSN_DIR_READ;
        `PGSN_ADDR_ANA_LVL:
          rdata_nxt = {`PGSN_ANA_PAD, ana_lvl};
        `PGSN_ADDR_IRQ_DATA:
          rdata_nxt = pgsn_port_read({6'b111111, irq_dir_r[1:0]}, irq_data_r,
                                     {6'b000000, irq_lvl}, `PGSN_FIXED_IRQ_DATA);
        `PGSN_ADDR_SER_DATA:
          rdata_nxt = pgsn_port_read(ser_dir_used | 8'h2a, ser_data_r,
                                     ser_lvl_wide, `PGSN_FIXED_SER_DATA);
        default:
          rdata_nxt = `PGSN_UNMAPPED_READ;
      endcase
    end
  end

  // Pin drive is computed from next register state so a write shows next cycle
  always @*
  begin
    irq_out_nxt = {1'b0, irq_data_nxt[0]};
    irq_oe_nxt  = {1'b0, irq_dir_nxt[0]};
    ser_out_nxt = {ser_data_nxt[4], ser_data_nxt[2], ser_data_nxt[0]};
    ser_oe_nxt  = {ser_dir_nxt[4], ser_dir_nxt[2], ser_dir_nxt[0]};
    if (serial_transmitter_enable_i)
    begin
      ser_oe_nxt[`PGSN_SER_TX_PIN]  = 1'b1;
      ser_out_nxt[`PGSN_SER_TX_PIN] = txd_i;
    end
    if (serial_receiver_enable_i)
    begin
      ser_oe_nxt[`PGSN_SER_RX_PIN]  = 1'b0;
      ser_out_nxt[`PGSN_SER_RX_PIN] = 1'b0;
    end
    if (sck_own_i)
    begin
      ser_oe_nxt[`PGSN_SER_CK_PIN]  = sck_drive_i;
      ser_out_nxt[`PGSN_SER_CK_PIN] = sck_out_i;
    end
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_dir_r            <= `PGSN_RST_IRQ_DIR;
      irq_data_r           <= `PGSN_RST_IRQ_DATA;
      ser_dir_r            <= `PGSN_RST_SER_DIR;
      ser_data_r           <= `PGSN_RST_SER_DATA;
      rdata_o              <= `PGSN_ZERO8;
      adc_in_o             <= 4'h0;
      irq_pin_o            <= 2'h0;
      irq_pin_oe_o         <= 2'h0;
      ext_interrupt_zero_o <= 1'b0;
      ext_interrupt_one_o  <= 1'b0;
      ser_pin_o            <= 3'h0;
      ser_pin_oe_o         <= 3'h0;
      ext_interrupt_four_o <= 1'b0;
      rxd_o                <= 1'b0;
      sck_in_o             <= 1'b0;
    end
    else
    begin
      irq_dir_r            <= irq_dir_nxt;
      irq_data_r           <= irq_data_nxt;
      ser_dir_r            <= ser_dir_nxt;
      ser_data_r           <= ser_data_nxt;
      rdata_o              <= rdata_nxt;
      adc_in_o             <= ana_lvl;
      irq_pin_o            <= irq_out_nxt;
      irq_pin_oe_o         <= irq_oe_nxt;
      ext_interrupt_zero_o <= irq_lvl[0];
      ext_interrupt_one_o  <= irq_lvl[1];
      ser_pin_o            <= ser_out_nxt;
      ser_pin_oe_o         <= ser_oe_nxt;
      ext_interrupt_four_o <= ser_lvl[`PGSN_SER_CK_PIN];
      rxd_o                <= ser_lvl[`PGSN_SER_RX_PIN];
      sck_in_o             <= ser_lvl[`PGSN_SER_CK_PIN];
    end
  end

endmodule // pgsn_top

// ===== test/pgsn_checker.sv
// Assertions on register reads and pin drive of the port group block
`timescale 1ns/100ps
`include "pgsn_regs.vh"
module pgsn_checker
(
  // Clock, reset and register port
  input wire logic        clk_i, rstn_i, hw_standby_i, wr_i, rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i, rdata_o,
  // Pins and serial side
  input wire logic [3:0]  adc_in_o,
  input wire logic [1:0]  irq_pin_oe_o,
  input wire logic [2:0]  ser_pin_o, ser_pin_oe_o,
  input wire logic        txd_i, serial_receiver_enable_i, serial_transmitter_enable_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Writes in standby, or serial writes under a transmit override, do not show on pin 0
  wire w_ok = wr_i && !hw_standby_i && !serial_transmitter_enable_i;
  chk_ana_levels: assert property (rd_i && addr_i == `PGSN_ADDR_ANA_LVL |=>
    rdata_o == {4'h0, adc_in_o}) else $error("analog read wrong");
  chk_dir_ones: assert property (rd_i && (addr_i == `PGSN_ADDR_IRQ_DIR ||
    addr_i == `PGSN_ADDR_SER_DIR) |=> rdata_o == 8'hff) else $error("direction read");
  chk_irq_fixed: assert property (rd_i && addr_i == `PGSN_ADDR_IRQ_DATA |=>
    &rdata_o[7:5]) else $error("irq fixed bits");
  chk_ser_fixed: assert property (rd_i && addr_i == `PGSN_ADDR_SER_DATA |=>
    &rdata_o[7:6]) else $error("serial fixed bits");
  chk_irq_dir_write: assert property (w_ok && addr_i == `PGSN_ADDR_IRQ_DIR |=>
    irq_pin_oe_o[0] == $past(wdata_i[0])) else $error("irq pin0 direction");
  chk_ser_dir_write: assert property (w_ok && addr_i == `PGSN_ADDR_SER_DIR |=>
    ser_pin_oe_o[0] == $past(wdata_i[0])) else $error("serial pin0 direction");
  chk_tx_override: assert property (serial_transmitter_enable_i |=>
    ser_pin_oe_o[0] && ser_pin_o[0] == $past(txd_i)) else $error("transmit override");
  chk_rx_input: assert property (serial_receiver_enable_i |=> !ser_pin_oe_o[1])
    else $error("receive pin driven");
  cover property (wr_i && addr_i == `PGSN_ADDR_IRQ_DIR);
  cover property (rd_i && addr_i == `PGSN_ADDR_SER_DATA);
  cover property (serial_transmitter_enable_i && serial_receiver_enable_i);
endmodule // pgsn_checker
bind pgsn_top pgsn_checker pgsn_checker_i (.clk_i, .rstn_i, .hw_standby_i, .wr_i, .rd_i,
  .addr_i, .wdata_i, .rdata_o, .adc_in_o, .irq_pin_oe_o, .ser_pin_o, .ser_pin_oe_o,
  .txd_i, .serial_receiver_enable_i, .serial_transmitter_enable_i);

// ===== test/pgsn_board.sv
// Board model: each shared pin level from block drive and board level
`timescale 1ns/100ps
module pgsn_board
(
  // Block drive and board levels
  input  wire logic [1:0] irq_drv_i, irq_oe_i, irq_lvl_i,
  input  wire logic [2:0] ser_drv_i, ser_oe_i, ser_lvl_i,
  // Pin levels
  output wire logic [1:0] irq_pin_o,
  output wire logic [2:0] ser_pin_o
);
  // A driven pin reads back its own drive
  assign irq_pin_o = (irq_oe_i & irq_drv_i) | (~irq_oe_i & irq_lvl_i);
  assign ser_pin_o = (ser_oe_i & ser_drv_i) | (~ser_oe_i & ser_lvl_i);
endmodule // pgsn_board

// ===== test/test_pgsn_top.sv
// Self-checking bench for the port group block
`timescale 1ns/100ps
`include "pgsn_regs.vh"
module test_pgsn_top;
  logic        clk_i = 0, rstn_i = 0, hw_standby_i = 0, wr_i = 0, rd_i = 0, rxd_o;
  logic        re = 0, te = 0, txd = 1, ext0, ext1, ext4, sck_in;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0]  wdata_i = 8'h00, rdata_o;
  logic [3:0]  ana_pin_i = 4'ha, adc_in_o;
  logic [1:0]  irq_lvl = 2'b11, irq_pin_i, irq_pin_o, irq_pin_oe_o;
  logic [2:0]  ser_lvl = 3'b111, ser_pin_i, ser_pin_o, ser_pin_oe_o;
  int          mismatches = 0, checks = 0;
  pgsn_top pgsn_top_i (.clk_i, .rstn_i, .hw_standby_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .ana_pin_i, .adc_in_o, .irq_pin_i, .irq_pin_o, .irq_pin_oe_o,
    .ext_interrupt_zero_o(ext0), .ext_interrupt_one_o(ext1), .ser_pin_i, .ser_pin_o,
    .ser_pin_oe_o, .ext_interrupt_four_o(ext4), .serial_receiver_enable_i(re),
    .serial_transmitter_enable_i(te), .txd_i(txd), .sck_own_i(1'b0), .sck_drive_i(1'b0),
    .sck_out_i(1'b0), .rxd_o, .sck_in_o(sck_in));
  pgsn_board pgsn_board_i (.irq_drv_i(irq_pin_o), .irq_oe_i(irq_pin_oe_o), .irq_lvl_i(irq_lvl),
    .ser_drv_i(ser_pin_o), .ser_oe_i(ser_pin_oe_o), .ser_lvl_i(ser_lvl),
    .irq_pin_o(irq_pin_i), .ser_pin_o(ser_pin_i));
  always #12.5 clk_i = ~clk_i;
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk($sformatf("read %h", a), rdata_o, e);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    mismatches++;
    stop_test;
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1 chk("oe", {irq_pin_oe_o, ser_pin_oe_o}, 8'h00);
    rd(`PGSN_ADDR_ANA_LVL, 8'h0a);
    rd(`PGSN_ADDR_IRQ_DIR, 8'hff);
    rd(16'hffd1, 8'h00);
    rd(`PGSN_ADDR_SER_DIR, 8'hff);
    rd(`PGSN_ADDR_IRQ_DATA, 8'he3);
    rd(`PGSN_ADDR_SER_DATA, 8'hd5);
    irq_lvl <= 2'b00;
    wr(`PGSN_ADDR_IRQ_DIR, 8'h01);
    wr(`PGSN_ADDR_IRQ_DATA, 8'h1d);
    #1 chk("irq drive", {irq_pin_oe_o, irq_pin_o}, 8'h05);
    repeat (3) @(posedge clk_i);
    rd(`PGSN_ADDR_IRQ_DATA, 8'hfd);
    wr(`PGSN_ADDR_IRQ_DATA, 8'h00);
    rd(`PGSN_ADDR_IRQ_DATA, 8'he0);
    wr(`PGSN_ADDR_SER_DIR, 8'hff);
    wr(`PGSN_ADDR_SER_DATA, 8'h2a);
    #1 chk("ser drive", {ser_pin_oe_o, ser_pin_o}, 8'h38);
    rd(`PGSN_ADDR_SER_DATA, 8'hea);
    wr(`PGSN_ADDR_SER_DIR, 8'h14);
    repeat (6) @(posedge clk_i);
    rd(`PGSN_ADDR_SER_DATA, 8'heb);
    wr(`PGSN_ADDR_SER_DIR, 8'hff);
    wr(`PGSN_ADDR_SER_DATA, 8'h15);
    te <= 1'b1;
    re <= 1'b1;
    txd <= 1'b0;
    ser_lvl <= 3'b101;
    repeat (2) @(posedge clk_i);
    #1 chk("link pins", {ser_pin_oe_o, ser_pin_o}, 8'h2c);
    repeat (6) @(posedge clk_i);
    #1 chk("rxd", rxd_o, 8'h00);
    chk("ext irq", {ext0, ext1, ext4, sck_in}, 8'h03);
    @(posedge clk_i);
    te <= 1'b0;
    re <= 1'b0;
    hw_standby_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    wr(`PGSN_ADDR_IRQ_DATA, 8'h1c);
    hw_standby_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 chk("standby oe", {irq_pin_oe_o, ser_pin_oe_o}, 8'h00);
    rd(`PGSN_ADDR_IRQ_DATA, 8'he0);
    rd(`PGSN_ADDR_SER_DATA, 8'hd1);
    stop_test;
  end
endmodule // test_pgsn_top
